// ---- core/esiu_pointer_file.v ----
// Three file select pointers with one write port and three registered outputs
`timescale 1ns/1ns
module esiu_pointer_file #(
    parameter PTR_W = 12
) (
    // Clock and reset
    input wire core_clk,
    input wire rstSync_b,
    // Write port
    input wire wrEn,
    input wire [1:0] wrSel,
    input wire [PTR_W-1:0] wrData,
    // Outputs, all registered
    output reg [PTR_W-1:0] ptr0_q,
    output reg [PTR_W-1:0] ptr1_q,
    output reg [PTR_W-1:0] ptr2_q
);
    // Pointer storage
    always @(posedge core_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            ptr0_q <= {PTR_W{1'b0}};
            ptr1_q <= {PTR_W{1'b0}};
            ptr2_q <= {PTR_W{1'b0}};
        end else if (wrEn) begin
            case (wrSel)
                2'h0: ptr0_q <= wrData;
                2'h1: ptr1_q <= wrData;
                default: ptr2_q <= wrData;
            endcase
        end
    end
endmodule

// ---- core/esiu_unit.v ----
// Decode and execute of the extended stack instructions
`timescale 1ns/1ns
`include "esiu_consts.vh"
module esiu_unit #(
    parameter PTR_W = 12,
    parameter PC_W = 21
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Configuration and fetch
    input wire extension_enable_cfg,
    input wire instValid,
    input wire [15:0] instWord,
    // Standard operand remap request
    input wire [7:0] stdOperand,
    input wire stdAccessBit,
    // Core state
    input wire [PC_W-1:0] progCounter,
    input wire [7:0] working_accumulator,
    input wire [7:0] high_pc_latch,
    input wire [7:0] upper_pc_latch,
    input wire [PC_W-1:0] return_stack_top,
    input wire [7:0] memRdData,
    // Data memory port
    output reg memRdEn_q,
    output reg [PTR_W-1:0] memRdAddr_q,
    output reg memWrEn_q,
    output reg [PTR_W-1:0] memWrAddr_q,
    output reg [7:0] memWrData_q,
    // Program counter and return stack
    output reg pcLoad_q,
    output reg [PC_W-1:0] pcLoadValue_q,
    output reg stackPush_q,
    output reg [PC_W-1:0] stackPushValue_q,
    output reg stackPop_q,
    // Status to the core
    output reg extHit_q,
    output reg nopCycle_q,
    output reg stdIndexed_q,
    output reg [PTR_W-1:0] stdAddr_q,
    output reg [PTR_W-1:0] file_select_pointer0_q,
    output reg [PTR_W-1:0] file_select_pointer1_q,
    output reg [PTR_W-1:0] soft_stack_pointer_q
);
    // ==========================================
    // Reset release and state codes
    localparam ST_IDLE = 2'h0;
    localparam ST_NOP = 2'h1;
    localparam ST_MOVE2 = 2'h2;
    localparam ST_MOVE3 = 2'h3;
    reg rstMeta_q;
    reg rstSync_b;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_b <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_b <= rstMeta_q;
        end
    end

    // Configuration bit is a static pin, synchronised anyway
    reg cfgMeta_q;
    reg cfgEn_q;
    always @(posedge core_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            cfgMeta_q <= 1'b0;
            cfgEn_q <= 1'b0;
        end else begin
            cfgMeta_q <= extension_enable_cfg;
            cfgEn_q <= cfgMeta_q;
        end
    end

    // ==========================================
    // Helpers
    // Indirect registers are the top five bytes of each of the three eight-byte groups from 0xFC8 to 0xFDF
    function isIndirect;
        input [PTR_W-1:0] a;
        reg [PTR_W-1:0] grp;
        integer i;
        begin
            isIndirect = 1'b0;
            grp = `ESIU_IND_LO;
            for (i = 0; i < `ESIU_IND_COUNT; i = i + 1) begin
                if ((a & `ESIU_IND_MASK) == (grp & `ESIU_IND_MASK))
                    isIndirect = isIndirect | (a[2:0] >= `ESIU_IND_FIRST);
                grp = grp - `ESIU_IND_STRIDE;
            end
        end
    endfunction
    function [PTR_W-1:0] offsetAddr;
        input [PTR_W-1:0] base;
        input [6:0] off;
        begin
            offsetAddr = base + {{(PTR_W-7){1'b0}}, off};
        end
    endfunction

    // ==========================================
    // Pointer file
    reg ptrWrEn;
    reg [1:0] ptrWrSel;
    reg [PTR_W-1:0] ptrWrData;
    wire [PTR_W-1:0] ptr0;
    wire [PTR_W-1:0] ptr1;
    wire [PTR_W-1:0] ptr2;
    esiu_pointer_file #(.PTR_W(PTR_W)) uPtr (
        .core_clk(core_clk),
        .rstSync_b(rstSync_b),
        .wrEn(ptrWrEn),
        .wrSel(ptrWrSel),
        .wrData(ptrWrData),
        .ptr0_q(ptr0),
        .ptr1_q(ptr1),
        .ptr2_q(ptr2)
    );

    // ==========================================
    // Decode
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg moveIdx_q;
    reg [PTR_W-1:0] srcAddr_q;
    reg [PTR_W-1:0] srcAddr_d;
    reg moveIdx_d;
    wire [7:0] opHi = instWord[15:8];
    wire [1:0] sel = instWord[7:6];
    wire [PTR_W-1:0] lit6 = {{(PTR_W-6){1'b0}}, instWord[5:0]};
    wire take = instValid & cfgEn_q & (state_q == ST_IDLE);
    wire isAdd = take & (opHi == `ESIU_OP_ADD);
    wire isSub = take & (opHi == `ESIU_OP_SUB);
    wire isLink = (isAdd | isSub) & (sel == `ESIU_SEL_LINK);
    wire isPush = take & (opHi == `ESIU_OP_PUSH);
    wire isMove = take & (opHi == `ESIU_OP_MOVE);
    wire isCall = take & (instWord == `ESIU_OP_CALL_VIA_ACCUMULATOR);
    wire secondOk = instValid & (instWord[15:12] == `ESIU_SECOND_NIB);
    reg [PTR_W-1:0] selPtr;
    always @* begin
        case (sel)
            2'h0: selPtr = ptr0;
            2'h1: selPtr = ptr1;
            default: selPtr = ptr2;
        endcase
    end

    // Pointer update and next state
    always @* begin
        ptrWrEn = 1'b0;
        ptrWrSel = sel;
        ptrWrData = selPtr;
        state_d = state_q;
        srcAddr_d = srcAddr_q;
        moveIdx_d = moveIdx_q;
        if (isLink) begin
            ptrWrEn = 1'b1;
            ptrWrSel = `ESIU_SEL_STACK;
            ptrWrData = isAdd ? ptr2 + lit6 : ptr2 - lit6;
            state_d = ST_NOP;
        end else if (isAdd | isSub) begin
            ptrWrEn = 1'b1;
            ptrWrData = isAdd ? selPtr + lit6 : selPtr - lit6;
        end else if (isPush) begin
            ptrWrEn = 1'b1;
            ptrWrSel = `ESIU_SEL_STACK;
            ptrWrData = ptr2 - {{(PTR_W-1){1'b0}}, 1'b1};
        end else if (isCall) begin
            state_d = ST_NOP;
        end else if (isMove) begin
            srcAddr_d = offsetAddr(ptr2, instWord[6:0]);
            moveIdx_d = instWord[7];
            state_d = ST_MOVE2;
        end else if (state_q == ST_NOP) begin
            state_d = ST_IDLE;
        end else if (state_q == ST_MOVE2 && secondOk) begin
            state_d = ST_MOVE3;
        end else if (state_q == ST_MOVE3) begin
            state_d = ST_IDLE;
        end
    end

    // ==========================================
    // Sequencer and output registers
    reg [PTR_W-1:0] dstAddr_q;
    reg dstBlock_q;
    always @(posedge core_clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            state_q <= ST_IDLE;
            moveIdx_q <= 1'b0;
            srcAddr_q <= {PTR_W{1'b0}};
            dstAddr_q <= {PTR_W{1'b0}};
            dstBlock_q <= 1'b0;
            memRdEn_q <= 1'b0;
            memRdAddr_q <= {PTR_W{1'b0}};
            memWrEn_q <= 1'b0;
            memWrAddr_q <= {PTR_W{1'b0}};
            memWrData_q <= 8'h00;
            pcLoad_q <= 1'b0;
            pcLoadValue_q <= {PC_W{1'b0}};
            stackPush_q <= 1'b0;
            stackPushValue_q <= {PC_W{1'b0}};
            stackPop_q <= 1'b0;
            extHit_q <= 1'b0;
            nopCycle_q <= 1'b0;
            stdIndexed_q <= 1'b0;
            stdAddr_q <= {PTR_W{1'b0}};
            file_select_pointer0_q <= {PTR_W{1'b0}};
            file_select_pointer1_q <= {PTR_W{1'b0}};
            soft_stack_pointer_q <= {PTR_W{1'b0}};
        end else begin
            state_q <= state_d;
            srcAddr_q <= srcAddr_d;
            moveIdx_q <= moveIdx_d;
            file_select_pointer0_q <= ptr0;
            file_select_pointer1_q <= ptr1;
            soft_stack_pointer_q <= ptr2;
            extHit_q <= isAdd | isSub | isPush | isMove | isCall;
            nopCycle_q <= (state_q == ST_NOP);
            memRdEn_q <= 1'b0;
            memWrEn_q <= 1'b0;
            pcLoad_q <= 1'b0;
            stackPush_q <= 1'b0;
            stackPop_q <= 1'b0;
            // Return variants load PC from the stack top
            if (isLink) begin
                pcLoad_q <= 1'b1;
                pcLoadValue_q <= return_stack_top;
                stackPop_q <= 1'b1;
            end
            // Call through accumulator, no accumulator or status write
            if (isCall) begin
                stackPush_q <= 1'b1;
                stackPushValue_q <= progCounter + `ESIU_PC_STEP;
                pcLoad_q <= 1'b1;
                pcLoadValue_q <= {upper_pc_latch[PC_W-17:0], high_pc_latch, working_accumulator};
            end
            // Push literal at stack pointer
            if (isPush) begin
                memWrEn_q <= 1'b1;
                memWrAddr_q <= ptr2;
                memWrData_q <= instWord[7:0];
            end
            // Move: read source, second word gives destination
            if (isMove) begin
                memRdEn_q <= 1'b1;
                memRdAddr_q <= srcAddr_d;
            end
            if (state_q == ST_MOVE2 && secondOk) begin
                if (moveIdx_q) begin
                    dstAddr_q <= offsetAddr(ptr2, instWord[6:0]);
                    dstBlock_q <= isIndirect(offsetAddr(ptr2, instWord[6:0]));
                end else begin
                    dstAddr_q <= instWord[11:0];
                    dstBlock_q <= 1'b0;
                end
            end
            if (state_q == ST_MOVE3) begin
                memWrEn_q <= ~dstBlock_q;
                memWrAddr_q <= dstAddr_q;
                memWrData_q <= isIndirect(srcAddr_q) ? 8'h00 : memRdData;
            end
            // Standard operand remap onto the stack pointer
            stdIndexed_q <= cfgEn_q & ~stdAccessBit & (stdOperand <= `ESIU_INDEX_LIMIT);
            stdAddr_q <= offsetAddr(ptr2, stdOperand[6:0]);
        end
    end
endmodule

// ---- pkg/esiu_consts.vh ----
// Constants for the extended stack instruction unit
`ifndef ESIU_CONSTS_VH
`define ESIU_CONSTS_VH
`define ESIU_OP_ADDSUB 8'hE8
`define ESIU_OP_ADD 8'hE8
`define ESIU_OP_SUB 8'hE9
`define ESIU_OP_PUSH 8'hFA
`define ESIU_OP_MOVE 8'hEB
`define ESIU_OP_CALL_VIA_ACCUMULATOR 16'h0014
`define ESIU_SECOND_NIB 4'hF
`define ESIU_SEL_STACK 2'h2
`define ESIU_SEL_LINK 2'h3
`define ESIU_INDEX_LIMIT 8'h5F
`define ESIU_PC_STEP 21'h000002
`define ESIU_IND_LO 12'hFDF
`define ESIU_IND_MASK 12'hFF8
`define ESIU_IND_STRIDE 12'h008
`define ESIU_IND_COUNT 3
`define ESIU_IND_FIRST 3'h3
`endif

// ---- testbench/esiu_mem_model.sv ----
// Data memory partner model for the extended stack unit
`timescale 1ns/1ns
module esiu_mem_model (
    // Clock and read port
    input wire core_clk,
    input wire memRdEn_q,
    input wire [11:0] memRdAddr_q,
    output reg [7:0] memRdData
);
    // ==========
    // Read data lands the cycle after the strobe; idle cycles wander
    initial memRdData = 8'h00;
    always @(posedge core_clk) begin
        if (memRdEn_q) begin
            memRdData <= memRdAddr_q[7:0] ^ 8'h5A;
        end else begin
            memRdData <= ~memRdData;
        end
    end
endmodule

// ---- testbench/esiu_unit_sva.sv ----
// Port checker for the extended stack unit
`timescale 1ns/1ns
module esiu_unit_sva #(parameter PTR_W = 12, parameter PC_W = 21) (
    // Clock, reset and fetch
    input wire core_clk, input wire rst_b, input wire extension_enable_cfg, input wire instValid,
    input wire [15:0] instWord, input wire [7:0] stdOperand, input wire stdAccessBit,
    // Core state
    input wire [PC_W-1:0] progCounter, input wire [7:0] working_accumulator, input wire [7:0] high_pc_latch,
    input wire [7:0] upper_pc_latch, input wire [PC_W-1:0] return_stack_top,
    // Watched outputs
    input wire memRdEn_q, input wire memWrEn_q, input wire [PTR_W-1:0] memWrAddr_q, input wire [7:0] memWrData_q,
    input wire pcLoad_q, input wire [PC_W-1:0] pcLoadValue_q, input wire stackPush_q,
    input wire [PC_W-1:0] stackPushValue_q, input wire extHit_q, input wire nopCycle_q, input wire stdIndexed_q,
    input wire [PTR_W-1:0] stdAddr_q, input wire [PTR_W-1:0] file_select_pointer0_q,
    input wire [PTR_W-1:0] soft_stack_pointer_q
);
    // ==========
    // Enable history, so checks wait out the enable synchroniser
    reg [2:0] enHist_q;
    reg rdLast_q;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            enHist_q <= 3'h0;
            rdLast_q <= 1'b0;
        end else begin
            enHist_q <= {enHist_q[1:0], extension_enable_cfg};
            rdLast_q <= memRdEn_q;
        end
    end
    wire isOn = (&enHist_q) && extension_enable_cfg;
    wire isOff = !(|enHist_q) && !extension_enable_cfg;
    // Both move follow-up cycles are busy, so skip them as well
    wire take = isOn && instValid && !pcLoad_q && !memRdEn_q && !rdLast_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // Assertions
    push_write_a: assert property (
        take && instWord[15:8] == 8'hFA |=> memWrEn_q && memWrData_q == $past(instWord[7:0])
        && memWrAddr_q == soft_stack_pointer_q) else $error("push write wrong");
    push_dec_a: assert property (
        take && instWord[15:8] == 8'hFA |-> ##2 soft_stack_pointer_q == $past(soft_stack_pointer_q) - 12'h001)
        else $error("push decrement wrong");
    add_stack_a: assert property (
        take && instWord[15:6] == 10'h3A2 |-> ##2
        soft_stack_pointer_q == $past(soft_stack_pointer_q) + {6'h00, $past(instWord[5:0], 2)})
        else $error("pointer add wrong");
    sub_pointer_a: assert property (
        take && instWord[15:6] == 10'h3A4 |-> ##2
        file_select_pointer0_q == $past(file_select_pointer0_q) - {6'h00, $past(instWord[5:0], 2)})
        else $error("pointer subtract wrong");
    link_return_a: assert property (
        take && instWord[15:9] == 7'h74 && instWord[7:6] == 2'h3 |=> pcLoad_q
        && pcLoadValue_q == $past(return_stack_top) ##1 nopCycle_q) else $error("linked return wrong");
    call_acc_a: assert property (
        take && instWord == 16'h0014 |=> stackPush_q && stackPushValue_q == $past(progCounter) + 21'h000002
        && pcLoad_q && pcLoadValue_q == {$past(upper_pc_latch[4:0]), $past(high_pc_latch),
        $past(working_accumulator)} ##1 nopCycle_q) else $error("call via accumulator wrong");
    ext_off_a: assert property (
        isOff && instValid |=> !extHit_q && !memWrEn_q && !pcLoad_q && !stdIndexed_q)
        else $error("extension active while off");
    std_remap_a: assert property (
        isOn && !instValid && !$past(instValid) && !$past(instValid, 2) |=>
        stdIndexed_q == ($past(stdOperand) <= 8'h5F && !$past(stdAccessBit))
        && (!stdIndexed_q || stdAddr_q == soft_stack_pointer_q + {5'h00, $past(stdOperand[6:0])}))
        else $error("operand remap wrong");
    // Main scenarios
    cover property (take && instWord[15:8] == 8'hEB);
    cover property (take && instWord == 16'h0014);
    cover property (take && instWord[15:8] == 8'hFA);
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the extended stack unit
`timescale 1ns/1ns
module tb;
    reg core_clk, rst_b, en, instValid, stdAccessBit;
    reg [15:0] instWord;
    reg [7:0] stdOperand, wAcc, hiLatch, upLatch;
    reg [20:0] progCounter, retTop;
    wire [7:0] memRdData, memWrData_q;
    wire memRdEn_q, memWrEn_q, pcLoad_q, stackPush_q, stackPop_q, extHit_q, nopCycle_q, stdIndexed_q;
    wire [11:0] memRdAddr_q, memWrAddr_q, stdAddr_q, ptr0, ptr1, ptr2;
    wire [20:0] pcLoadValue_q, stackPushValue_q;
    integer num_errors = 0;
    integer comparisons = 0;
    esiu_unit DUT (.core_clk(core_clk), .rst_b(rst_b), .extension_enable_cfg(en), .instValid(instValid),
        .instWord(instWord), .stdOperand(stdOperand), .stdAccessBit(stdAccessBit), .progCounter(progCounter),
        .working_accumulator(wAcc), .high_pc_latch(hiLatch), .upper_pc_latch(upLatch),
        .return_stack_top(retTop), .memRdData(memRdData), .memRdEn_q(memRdEn_q), .memRdAddr_q(memRdAddr_q),
        .memWrEn_q(memWrEn_q), .memWrAddr_q(memWrAddr_q), .memWrData_q(memWrData_q), .pcLoad_q(pcLoad_q),
        .pcLoadValue_q(pcLoadValue_q), .stackPush_q(stackPush_q), .stackPushValue_q(stackPushValue_q),
        .stackPop_q(stackPop_q), .extHit_q(extHit_q), .nopCycle_q(nopCycle_q), .stdIndexed_q(stdIndexed_q),
        .stdAddr_q(stdAddr_q), .file_select_pointer0_q(ptr0), .file_select_pointer1_q(ptr1),
        .soft_stack_pointer_q(ptr2));
    esiu_mem_model u_mem (.core_clk(core_clk), .memRdEn_q(memRdEn_q), .memRdAddr_q(memRdAddr_q),
        .memRdData(memRdData));
    // ==========
    // Helpers
    task chk(input c, input [8*16:1] m);
        comparisons++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: %0s", $time, m);
        end
    endtask
    task idle(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    task issue(input [15:0] w);
        @(negedge core_clk) instValid = 1'b1;
        instWord = w;
        @(negedge core_clk) instValid = 1'b0;
    endtask
    // Two-word move; destinations never name the PC low or stack-top bytes
    task move(input [15:0] w1, w2, input [11:0] rd, input wr, input [11:0] wa, input [7:0] d);
        @(negedge core_clk) instValid = 1'b1;
        instWord = w1;
        @(negedge core_clk) instWord = w2;
        chk(memRdEn_q === 1'b1 && memRdAddr_q === rd, "move read");
        @(negedge core_clk) instValid = 1'b0;
        @(negedge core_clk);
        chk(memWrEn_q === wr && (!wr || (memWrAddr_q === wa && memWrData_q === d)), "move write");
    endtask
    task print_verdict;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========
    // Clock, watchdog and scenarios
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000 num_errors++;
        print_verdict;
    end
    initial begin
        {rst_b, en, instValid, stdAccessBit, instWord, stdOperand} = 0;
        {wAcc, hiLatch, upLatch, progCounter, retTop} = {8'h06, 8'h10, 8'h00, 21'h000100, 21'h00ABCD};
        idle(16);
        rst_b = 1'b1;
        idle(5);
        issue(16'hFA55);
        chk(memWrEn_q === 1'b0 && extHit_q === 1'b0, "off push");
        stdOperand = 8'h05;
        idle(3);
        chk(stdIndexed_q === 1'b0, "off remap");
        en = 1'b1;
        idle(5);
        issue(16'hFA08);
        chk(memWrEn_q === 1'b1 && memWrAddr_q === 12'h000 && memWrData_q === 8'h08
            && extHit_q === 1'b1, "push");
        idle(1);
        chk(ptr2 === 12'hFFF, "push dec");
        issue(16'hE8BF);
        idle(1);
        chk(ptr2 === 12'h03E, "add carry");
        issue(16'hE9BF);
        issue(16'hE9BE);
        issue(16'hE805);
        issue(16'hE901);
        issue(16'hE845);
        idle(1);
        chk(ptr2 === 12'hFC1 && ptr0 === 12'h004 && ptr1 === 12'h005, "sub borrow");
        move(16'hEB1E, 16'hF0AB, 12'hFDF, 1'b1, 12'h0AB, 8'h00);
        move(16'hEB81, 16'hF01E, 12'hFC2, 1'b0, 12'h000, 8'h00);
        move(16'hEB81, 16'hF005, 12'hFC2, 1'b1, 12'hFC6, 8'h98);
        issue(16'h0014);
        chk(stackPush_q === 1'b1 && stackPushValue_q === 21'h000102 && pcLoad_q === 1'b1
            && pcLoadValue_q === 21'h001006 && stackPop_q === 1'b0, "call");
        idle(1);
        chk(nopCycle_q === 1'b1, "call nop");
        issue(16'hE8C5);
        chk(pcLoad_q === 1'b1 && pcLoadValue_q === 21'h00ABCD && stackPop_q === 1'b1, "add return");
        idle(1);
        chk(nopCycle_q === 1'b1 && ptr2 === 12'hFC6, "add return ptr");
        issue(16'hE9C5);
        chk(pcLoad_q === 1'b1 && pcLoadValue_q === 21'h00ABCD && stackPop_q === 1'b1, "sub return");
        idle(1);
        chk(nopCycle_q === 1'b1 && ptr2 === 12'hFC1, "sub return ptr");
        stdOperand = 8'h5F;
        idle(3);
        chk(stdIndexed_q === 1'b1 && stdAddr_q === 12'h020, "remap");
        stdOperand = 8'h60;
        idle(3);
        chk(stdIndexed_q === 1'b0, "remap high");
        stdOperand = 8'h05;
        stdAccessBit = 1'b1;
        idle(3);
        chk(stdIndexed_q === 1'b0, "remap bank");
        print_verdict;
    end
endmodule
bind esiu_unit esiu_unit_sva #(.PTR_W(PTR_W), .PC_W(PC_W)) u_sva (.*);
